// File: sim/dpsm_checker_props.sv
// port assertions for the data port slot mask unit
`timescale 1ns/1ns
module dpsm_checker (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_msg_valid,
    input wire logic o_msg_ready,
    input wire dpsm_pkg::dpsm_slot_mode_t i_slot_mode,
    input wire logic i_write,
    input wire logic [15:0] i_exec_mask,
    input wire logic [dpsm_pkg::ELEM_W-1:0] i_elem_count,
    input wire logic [7:0] i_elem_bytes,
    input wire logic i_compressible,
    input wire logic o_acc_valid,
    input wire logic [15:0] o_acc_enable,
    input wire logic [15:0] o_acc_oob,
    input wire logic o_err_payload,
    input wire logic o_err_format,
    input wire logic o_msg_dropped
);
    logic take;
    // a message is taken on valid and ready together
    assign take = i_msg_valid && o_msg_ready;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_ready_gap: assert property (take |=> !o_msg_ready [*2] ##1 o_msg_ready)
        else $error("ready gap after take wrong");
    a_one_answer: assert property (take |=> o_acc_valid || o_err_payload ||
        o_err_format || o_msg_dropped) else $error("no answer after take");
    a_quiet_idle: assert property (!take |=> !o_acc_valid &&
        o_acc_enable == 16'h0000) else $error("issue without take");
    a_mask_gate: assert property (o_acc_valid |->
        (o_acc_enable & ~$past(i_exec_mask)) == 16'h0000)
        else $error("enable outside mask");
    a_simd8_upper: assert property (take &&
        i_slot_mode == dpsm_pkg::DPSM_SM_SIMD8 |=> o_acc_enable[15:8] == 8'h00)
        else $error("upper mask used in simd8");
    a_empty_drop: assert property (take &&
        i_slot_mode == dpsm_pkg::DPSM_SM_SIMD8 && i_exec_mask[7:0] == 8'h00
        |=> o_msg_dropped && !o_acc_valid)
        else $error("empty mask not dropped");
    a_oob_apart: assert property ((o_acc_enable & o_acc_oob) == 16'h0000)
        else $error("out of bounds slot enabled");
    a_comp_write: assert property (take && i_compressible && i_write
        |=> o_err_format && !o_acc_valid) else $error("compressible write");
    a_payload_cap: assert property (take && i_elem_count == 3'h7 &&
        i_slot_mode == dpsm_pkg::DPSM_SM_SIMD16 && i_elem_bytes > 8'h02
        |=> o_err_payload && !o_acc_valid) else $error("payload over cap");
endmodule // dpsm_checker

bind dpsm_top dpsm_checker u_dpsm_checker (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_msg_valid(i_msg_valid), .o_msg_ready(o_msg_ready),
    .i_slot_mode(i_slot_mode), .i_write(i_write), .i_exec_mask(i_exec_mask),
    .i_elem_count(i_elem_count), .i_elem_bytes(i_elem_bytes),
    .i_compressible(i_compressible), .o_acc_valid(o_acc_valid),
    .o_acc_enable(o_acc_enable), .o_acc_oob(o_acc_oob),
    .o_err_payload(o_err_payload), .o_err_format(o_err_format),
    .o_msg_dropped(o_msg_dropped));

// File: sim/dpsm_issuer.sv
// send path model: offers a message and holds it until taken
`timescale 1ns/1ns
module dpsm_issuer (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_go,
    input wire logic [15:0] i_mask,
    input wire logic i_ready,
    output logic o_valid
);
    // empty mask never sent, no write order relied on
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_valid <= 1'b0;
        end else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
        end else if (i_go && (i_mask != 16'h0000)) begin
            o_valid <= 1'b1;
        end
    end
endmodule // dpsm_issuer

// File: sim/tb.sv
// self-checking bench for the data port slot mask unit
`timescale 1ns/1ns
module tb;
    typedef struct {
        dpsm_pkg::dpsm_model_t m;
        dpsm_pkg::dpsm_slot_mode_t s;
        logic up;
        logic [15:0] mask;
        logic [15:0] en;
    } dpsm_row_t;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic upg = 1'b0;
    logic comp = 1'b0;
    logic valid, ready, acc_valid, acc_write, e_pay, e_fmt, drop;
    dpsm_pkg::dpsm_model_t model = dpsm_pkg::DPSM_AM_BINDING_TABLE;
    dpsm_pkg::dpsm_slot_mode_t smode = dpsm_pkg::DPSM_SM_SIMD8;
    logic [15:0] mask = 16'h00ff;
    logic [15:0] en, oob, merged;
    logic [31:0] limit = 32'h8000_0000;
    logic [31:0] hbase = 32'h0000_1000;
    logic [31:0] hoff = 32'h0000_0500;
    logic t2d = 1'b0;
    logic [31:0] sx = 32'h0000_0000;
    logic [31:0] sy = 32'h0000_0000;
    logic [31:0] pitch = 32'h0000_0000;
    logic [31:0] exp_a;
    logic [dpsm_pkg::ELEM_W-1:0] ecnt = 3'h0;
    logic [dpsm_pkg::ELEM_W-1:0] elems;
    logic [7:0] ebytes = 8'h04;
    logic [8:0] fmt = 9'h000;
    logic [511:0] offs = 512'h0;
    logic [511:0] addr;
    logic [31:0] res;
    int miscompares = 0;
    int n_checks = 0;
    dpsm_row_t rows[7];
    logic [8:0] fmts[13] = '{9'h106, 9'h109, 9'h10a, 9'h10d, 9'h113, 9'h140,
        9'h143, 9'h144, 9'h182, 9'h183, 9'h18f, 9'h190, 9'h141};

    // result code: dropped, format error, payload error, issued
    assign res = {28'h0, drop, e_fmt, e_pay, acc_valid};
    always #10 i_clk = ~i_clk;

    dpsm_issuer u_dpsm_issuer (.i_clk(i_clk), .i_resetn(i_resetn), .i_go(go),
        .i_mask(mask), .i_ready(ready), .o_valid(valid));
    // surface inputs only matter in the typed 2d case near the end
    dpsm_top u_dpsm_top (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_msg_valid(valid), .o_msg_ready(ready), .i_model(model),
        .i_slot_mode(smode), .i_write(wr), .i_upper_group(upg),
        .i_exec_mask(mask), .i_header_base(hbase), .i_header_offset(hoff),
        .i_surface_x(sx), .i_surface_pitch(pitch), .i_surface_y(sy),
        .i_typed_2d(t2d), .i_payload_offsets(offs), .i_elem_count(ecnt),
        .i_elem_bytes(ebytes), .i_bound_limit(limit), .i_compressible(comp),
        .i_surface_format(fmt), .o_acc_valid(acc_valid), .o_acc_enable(en),
        .o_acc_addr(addr), .o_acc_oob(oob), .o_acc_merged(merged),
        .o_acc_elems(elems), .o_acc_write(acc_write), .o_err_payload(e_pay),
        .o_err_format(e_fmt), .o_msg_dropped(drop));

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // entered at a falling edge, returns at the falling edge of the answer
    task automatic send;
        go = 1'b1;
        @(negedge i_clk);
        go = 1'b0;
        for (int k = 0; k < 8 && !(valid && ready); k++) @(negedge i_clk);
        chk("taken", 32'h1, {31'h0, valid && ready});
        @(negedge i_clk);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    initial begin
        rows = '{'{dpsm_pkg::DPSM_AM_BINDING_TABLE, dpsm_pkg::DPSM_SM_SIMD16,
            1'b0, 16'ha5c3, 16'ha5c3}, '{dpsm_pkg::DPSM_AM_SHARED_LOCAL,
            dpsm_pkg::DPSM_SM_SIMD8, 1'b0, 16'hff0f, 16'h000f},
            '{dpsm_pkg::DPSM_AM_FLAT32, dpsm_pkg::DPSM_SM_DUAL, 1'b0, 16'h00ff,
            16'h0003}, '{dpsm_pkg::DPSM_AM_FLAT64, dpsm_pkg::DPSM_SM_BLOCK,
            1'b0, 16'h8001, 16'h0001}, '{dpsm_pkg::DPSM_AM_TYPED,
            dpsm_pkg::DPSM_SM_SIMD16, 1'b1, 16'h0f0f, 16'h0f00},
            '{dpsm_pkg::DPSM_AM_TYPED, dpsm_pkg::DPSM_SM_SIMD16, 1'b0,
            16'h0f0f, 16'h000f}, '{dpsm_pkg::DPSM_AM_BINDING_TABLE,
            dpsm_pkg::DPSM_SM_SIMD8, 1'b0, 16'hff00, 16'h0000}};
        for (int n = 0; n < 16; n++) begin
            offs[32*n +: 32] = 32'(n) * 32'h100 + 32'h40;
        end
        repeat (6) @(negedge i_clk);
        i_resetn = 1'b1;
        // ordinary cases: every model and slot mode, both typed groups
        foreach (rows[i]) begin
            model = rows[i].m;
            smode = rows[i].s;
            upg = rows[i].up;
            mask = rows[i].mask;
            exp_a = (rows[i].s == dpsm_pkg::DPSM_SM_BLOCK) ? hoff : offs[31:0];
            exp_a = exp_a + ((rows[i].m == dpsm_pkg::DPSM_AM_FLAT32) ?
                hbase : 32'h0000_0000);
            send();
            chk("result", (rows[i].en == 16'h0) ? 32'h8 : 32'h1, res);
            chk("enable", {16'h0, rows[i].en}, {16'h0, en});
            if (rows[i].en[0] === 1'b1) chk("addr0", exp_a, addr[31:0]);
        end
        $display("end of mode table");
        // compressible reads: all listed formats plus one unlisted
        comp = 1'b1;
        model = dpsm_pkg::DPSM_AM_BINDING_TABLE;
        smode = dpsm_pkg::DPSM_SM_SIMD8;
        mask = 16'h00ff;
        foreach (fmts[i]) begin
            fmt = fmts[i];
            send();
            chk("fmt_err", {31'h0, i == 12}, {31'h0, e_fmt});
        end
        wr = 1'b1;
        send();
        chk("wr_result", 32'h4, res);
        comp = 1'b0;
        send();
        chk("write", 32'h3, {30'h0, acc_write, acc_valid});
        wr = 1'b0;
        $display("end of format test");
        // payload cap: exactly 256 bytes, then 512
        smode = dpsm_pkg::DPSM_SM_SIMD16;
        mask = 16'hffff;
        ecnt = 3'h3;
        send();
        chk("pay256", 32'h1, res);
        chk("elems", 32'h3, {29'h0, elems});
        ecnt = 3'h7;
        send();
        chk("pay512", 32'h2, res);
        ecnt = 3'h0;
        $display("end of payload test");
        // duplicate offset and bounds per slot
        smode = dpsm_pkg::DPSM_SM_SIMD8;
        mask = 16'h00ff;
        offs[63:32] = offs[31:0];
        limit = 32'h0000_0300;
        send();
        chk("oob", 32'h00f8, {16'h0, oob});
        chk("en_dup", 32'h0007, {16'h0, en});
        chk("merged", 32'h0002, {16'h0, merged});
        $display("end of bounds test");
        // typed 2d: lane offset plus row times pitch plus column
        model = dpsm_pkg::DPSM_AM_TYPED;
        t2d = 1'b1;
        sx = 32'h0000_0008;
        sy = 32'h0000_0002;
        pitch = 32'h0000_0040;
        send();
        chk("res_2d", 32'h1, res);
        chk("addr_2d", 32'h0000_00c8, addr[31:0]);
        t2d = 1'b0;
        $display("end of typed 2d test");
        // reset in mid-run, then one message again
        i_resetn = 1'b0;
        @(negedge i_clk);
        chk("rst_ready", 32'h1, {31'h0, ready});
        chk("rst_valid", 32'h0, {31'h0, acc_valid});
        i_resetn = 1'b1;
        send();
        chk("post_rst", 32'h1, res);
        $display("end of reset test");
        finish_test();
    end
endmodule // tb

// File: src/dpsm_pkg.sv
// shared constants and types of the data port slot mask unit
package dpsm_pkg;
    localparam int SLOTS = 16;
    localparam int HALF = 8;
    localparam int AW = 32;
    localparam int FMT_W = 9;
    localparam int ELEM_W = 3;
    localparam int MAX_PAYLOAD_BYTES = 256;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [AW-1:0] ADDR_RESET = 32'h0000_0000;

    // address models
    typedef enum logic [2:0] {
        DPSM_AM_BINDING_TABLE,
        DPSM_AM_SHARED_LOCAL,
        DPSM_AM_FLAT32,
        DPSM_AM_FLAT64,
        DPSM_AM_TYPED
    } dpsm_model_t;

    // slot modes: 1, 2, 8 or 16 slots
    typedef enum logic [1:0] {
        DPSM_SM_BLOCK,
        DPSM_SM_DUAL,
        DPSM_SM_SIMD8,
        DPSM_SM_SIMD16
    } dpsm_slot_mode_t;

    // issue state
    typedef enum logic [1:0] {
        DPSM_ST_IDLE,
        DPSM_ST_ISSUE,
        DPSM_ST_DONE
    } dpsm_state_t;

    // compressible media read formats
    localparam logic [FMT_W-1:0] FMT_R8G8_UNORM = 9'h106;
    localparam logic [FMT_W-1:0] FMT_R8G8_UINT = 9'h109;
    localparam logic [FMT_W-1:0] FMT_R16_UNORM = 9'h10a;
    localparam logic [FMT_W-1:0] FMT_R16_UINT = 9'h10d;
    localparam logic [FMT_W-1:0] FMT_A16_UNORM = 9'h113;
    localparam logic [FMT_W-1:0] FMT_R8_UNORM = 9'h140;
    localparam logic [FMT_W-1:0] FMT_R8_UINT = 9'h143;
    localparam logic [FMT_W-1:0] FMT_A8_UNORM = 9'h144;
    localparam logic [FMT_W-1:0] FMT_YUYV = 9'h182;
    localparam logic [FMT_W-1:0] FMT_VYUY = 9'h183;
    localparam logic [FMT_W-1:0] FMT_YVYU = 9'h18f;
    localparam logic [FMT_W-1:0] FMT_UYVY = 9'h190;
endpackage

// File: src/dpsm_slot_lane.sv
// one slot lane: address forming, bounds check and mask gate
`timescale 1ns/1ns
module dpsm_slot_lane (
    input wire logic [dpsm_pkg::AW-1:0] i_slot_offset,
    input wire logic [dpsm_pkg::AW-1:0] i_base,
    input wire logic i_add_base,
    input wire logic [dpsm_pkg::AW-1:0] i_limit,
    input wire logic i_lane_on,
    output logic [dpsm_pkg::AW-1:0] o_addr,
    output logic o_in_bounds,
    output logic o_enable
);
    // base offset only joins the flat 32-bit model
    assign o_addr = i_add_base ? i_slot_offset + i_base : i_slot_offset;
    // each access is checked on its own address
    assign o_in_bounds = (o_addr < i_limit);
    assign o_enable = i_lane_on && o_in_bounds;
endmodule // dpsm_slot_lane

// File: src/dpsm_top.sv
// data port front end: slot addressing, execution mask and format checks
// Contract
// - operands addressed as elements, slots, or both, per message type
// - slot offsets in any order, duplicates allowed, no error
// - merge accesses to fewer memory operations per cache line
// - all slot and element accesses issue in parallel
// - bounds check per individual access
// - flat 32-bit model adds header base offset to each slot
// - other models ignore the header base offset
// - typed messages use binding-table model, surface type forms offsets
// - block mode takes its single offset from the header
// - dual, simd8, simd16 take 2, 8, 16 offsets from payload
// - typed messages handle only upper or lower 8 slots
// - data payload of one message at most 256 bytes; payload_bytes is 12 bits wide, so larger sizes are checked modulo 4096
// - 16-bit execution mask, bit set means channel active
// - inactive channels modify neither registers nor memory
// - compressible reads accept only the listed media formats
// - simd8 uses low 8 mask bits, upper ignored; typed simd8 with i_upper_group uses bits 15:8 instead
// - unsupported compressible reads and all compressible writes flagged
`timescale 1ns/1ns
module dpsm_top (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_msg_valid,
    output logic o_msg_ready,
    input wire dpsm_pkg::dpsm_model_t i_model,
    input wire dpsm_pkg::dpsm_slot_mode_t i_slot_mode,
    input wire logic i_write,
    input wire logic i_upper_group,
    input wire logic [15:0] i_exec_mask,
    input wire logic [dpsm_pkg::AW-1:0] i_header_base,
    input wire logic [dpsm_pkg::AW-1:0] i_header_offset,
    input wire logic [dpsm_pkg::AW-1:0] i_surface_x,
    input wire logic [dpsm_pkg::AW-1:0] i_surface_pitch,
    input wire logic [dpsm_pkg::AW-1:0] i_surface_y,
    input wire logic i_typed_2d,
    input wire logic [dpsm_pkg::SLOTS*dpsm_pkg::AW-1:0] i_payload_offsets,
    input wire logic [dpsm_pkg::ELEM_W-1:0] i_elem_count,
    input wire logic [7:0] i_elem_bytes,
    input wire logic [dpsm_pkg::AW-1:0] i_bound_limit,
    input wire logic i_compressible,
    input wire logic [dpsm_pkg::FMT_W-1:0] i_surface_format,
    output logic o_acc_valid,
    output logic [15:0] o_acc_enable,
    output logic [dpsm_pkg::SLOTS*dpsm_pkg::AW-1:0] o_acc_addr,
    output logic [15:0] o_acc_oob,
    output logic [15:0] o_acc_merged,
    output logic [dpsm_pkg::ELEM_W-1:0] o_acc_elems,
    output logic o_acc_write,
    output logic o_err_payload,
    output logic o_err_format,
    output logic o_msg_dropped
);
    localparam int SLOTS = dpsm_pkg::SLOTS;
    localparam int AW = dpsm_pkg::AW;

    dpsm_pkg::dpsm_state_t state_reg;
    dpsm_pkg::dpsm_state_t state_next;

    logic [15:0] slot_lanes;
    logic [15:0] lane_on;
    logic [15:0] lane_en;
    logic [15:0] lane_inb;
    logic [15:0] lane_dup;
    logic [SLOTS*AW-1:0] lane_addr;
    logic add_base;
    logic is_typed;
    logic fmt_ok;
    logic [11:0] payload_bytes;
    logic payload_bad;
    logic format_bad;
    logic mask_zero;
    logic take;

    // slot/element select: lanes used by the slot mode
    // typed half: typed simd8 or simd16 picks one group of 8
    assign is_typed = (i_model == dpsm_pkg::DPSM_AM_TYPED);
    assign slot_lanes =
        (i_slot_mode == dpsm_pkg::DPSM_SM_BLOCK) ? 16'h0001 :
        (i_slot_mode == dpsm_pkg::DPSM_SM_DUAL) ? 16'h0003 :
        (is_typed && i_upper_group) ? 16'hff00 :
        (is_typed || i_slot_mode == dpsm_pkg::DPSM_SM_SIMD8) ? 16'h00ff :
        16'hffff;

    // mask gate: set bit means active channel
    // simd8 mask: slot_lanes drops the upper mask bits, or the lower ones for the typed upper group
    // bit n slot n: mask indexed by slot number
    assign lane_on = i_exec_mask & slot_lanes;

    // base add: only the flat 32-bit model adds it
    // base ignored: every other model leaves it out
    assign add_base = (i_model == dpsm_pkg::DPSM_AM_FLAT32);

    // payload cap: slots times elements times width
    assign payload_bytes = 12'(($countones(slot_lanes)) *
        (i_elem_count + 1) * i_elem_bytes);
    assign payload_bad = (payload_bytes > 12'(dpsm_pkg::MAX_PAYLOAD_BYTES));

    // format list: only these encodings decompress
    assign fmt_ok = (i_surface_format == dpsm_pkg::FMT_R8_UNORM)
        || (i_surface_format == dpsm_pkg::FMT_R8_UINT)
        || (i_surface_format == dpsm_pkg::FMT_A8_UNORM)
        || (i_surface_format == dpsm_pkg::FMT_R8G8_UNORM)
        || (i_surface_format == dpsm_pkg::FMT_R8G8_UINT)
        || (i_surface_format == dpsm_pkg::FMT_R16_UNORM)
        || (i_surface_format == dpsm_pkg::FMT_R16_UINT)
        || (i_surface_format == dpsm_pkg::FMT_A16_UNORM)
        || (i_surface_format == dpsm_pkg::FMT_YUYV)
        || (i_surface_format == dpsm_pkg::FMT_VYUY)
        || (i_surface_format == dpsm_pkg::FMT_YVYU)
        || (i_surface_format == dpsm_pkg::FMT_UYVY);
    // compressible misuse: writes always, reads off-list
    assign format_bad = i_compressible && (i_write || !fmt_ok);

    // zero mask: nothing is delivered to memory
    // nonzero needed: a blank mask is dropped here too
    assign mask_zero = (lane_on == 16'h0000);
    assign take = i_msg_valid && o_msg_ready;

    // per-slot lanes, all issued at once
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_lane
            logic [AW-1:0] off;
            // block offset: single slot takes the header offset
            // payload offsets: one per slot from the payload
            // typed offset: payload offset plus x plus y times pitch for 2d surfaces
            assign off = (i_slot_mode == dpsm_pkg::DPSM_SM_BLOCK) ?
                i_header_offset :
                (is_typed && i_typed_2d) ?
                i_payload_offsets[g*AW +: AW] +
                AW'(i_surface_y * i_surface_pitch) + i_surface_x :
                i_payload_offsets[g*AW +: AW];
            // parallel issue: every lane evaluated together
            // bounds each: one checker per access
            dpsm_slot_lane u_lane (
                .i_slot_offset(off),
                .i_base(i_header_base),
                .i_add_base(add_base),
                .i_limit(i_bound_limit),
                .i_lane_on(lane_on[g]),
                .o_addr(lane_addr[g*AW +: AW]),
                .o_in_bounds(lane_inb[g]),
                .o_enable(lane_en[g])
            );
            // merge: lane repeating a lower lane's line rides along
            // duplicates: repeated offsets are fine, just merged
            if (g == 0) begin : g_first
                assign lane_dup[g] = 1'b0;
            end else begin : g_rest
                logic [g-1:0] hit;
                for (genvar k = 0; k < g; k++) begin : g_cmp
                    assign hit[k] = lane_en[k] &&
                        (lane_addr[k*AW+6 +: AW-6] ==
                         lane_addr[g*AW+6 +: AW-6]);
                end
                assign lane_dup[g] = lane_en[g] && (|hit);
            end
        end
    endgenerate

    // accept, issue one cycle, done one cycle, then rearm
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dpsm_pkg::DPSM_ST_IDLE: begin
                if (i_msg_valid) begin
                    state_next = dpsm_pkg::DPSM_ST_ISSUE;
                end
            end
            dpsm_pkg::DPSM_ST_ISSUE: begin
                state_next = dpsm_pkg::DPSM_ST_DONE;
            end
            default: begin
                state_next = dpsm_pkg::DPSM_ST_IDLE;
            end
        endcase
    end

    // ready is high only in idle, so messages never overlap
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= dpsm_pkg::DPSM_ST_IDLE;
            o_msg_ready <= 1'b1;
        end else begin
            state_reg <= state_next;
            o_msg_ready <= (state_next == dpsm_pkg::DPSM_ST_IDLE);
        end
    end

    // inactive quiet: disabled lanes carry no enable
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_acc_valid <= 1'b0;
            o_acc_enable <= dpsm_pkg::MASK_RESET;
            o_acc_addr <= '0;
            o_acc_oob <= 16'h0000;
            o_acc_merged <= 16'h0000;
            o_acc_elems <= '0;
            o_acc_write <= 1'b0;
            o_err_payload <= 1'b0;
            o_err_format <= 1'b0;
            o_msg_dropped <= 1'b0;
        end else begin
            o_acc_valid <= take && !mask_zero && !payload_bad
                && !format_bad;
            o_acc_enable <= take ? lane_en : 16'h0000;
            o_acc_addr <= lane_addr;
            o_acc_oob <= take ? (lane_on & ~lane_inb) : 16'h0000;
            o_acc_merged <= take ? lane_dup : 16'h0000;
            o_acc_elems <= i_elem_count;
            o_acc_write <= i_write;
            o_err_payload <= take && payload_bad;
            o_err_format <= take && format_bad;
            o_msg_dropped <= take && mask_zero;
        end
    end
endmodule // dpsm_top
